//--- rtl/dcff_top.sv
// Deep word buffer with level flags, threshold offsets and AHB-Lite status port
//
// Overview of operation
// - A write strobe on a clock edge stores the input word.
// - A read strobe on a clock edge reads the next stored word.
// - Write and read sides work independently at any strobe rate.
// - Standard mode keeps the first word off the outputs until read.
// - Fall-through shows the first word after three edges; later words need reads.
// - Mode pin level during full init selects standard or fall-through.
// - Fall-through flags are active high, so chaining buffers in depth needs strobe inverters.
// - Shared flags show empty/full, or valid/space in fall-through.
// - Half, near-empty and near-full flags exist in both modes.
// - Near flags switch at separate programmed offsets from each boundary.
// - Offset select at full init picks 127 parallel or 1023 serial.
// - Serial load with offset select shifts one bit per edge.
// - Write strobe with offset select loads offsets from input word in parallel method.
// - Read strobe with offset select puts offsets on output word.
// - Full init zeroes pointers and refreshes flags from defaults.
// - Data-only init zeroes pointers, keeps mode, method and offsets.
// - Low rewind request moves the read pointer to location zero.
// - Output enable input controls output word drive.
// - Words are 18 bits, depth 8192 locations.
// - Both inits clear the output register to zero.
// - Rewind briefly shows empty, keeps write pointer and settings.
// - After full init the mode pin is only the serial input.
// - Fall-through space flag shows room, valid flag shows output data.
`timescale 1ns/10ps

module dcff_top
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Write side
  input wire logic write_n,
  input wire logic [dcff_pkg::WIDTH-1:0] input_word,
  // Read side
  input wire logic read_n,
  input wire logic output_enable_n,
  output logic [dcff_pkg::WIDTH-1:0] output_word,
  output logic output_word_oe,
  // Control
  input wire logic full_init_n,
  input wire logic data_only_init_n,
  input wire logic rewind_request_n,
  input wire logic mode_select_serial_in,
  input wire logic offset_access_select_n,
  input wire logic serial_load_enable_n,
  // Flags
  output logic empty_valid_flag,
  output logic full_space_flag,
  output logic half_level_flag,
  output logic near_empty_flag,
  output logic near_full_flag
);

  // ==========================================================
  // State
  typedef struct packed {
    dcff_pkg::dcff_mode_e mode;
    logic par_prog;
    logic [dcff_pkg::AW-1:0] empty_ofs;
    logic [dcff_pkg::AW-1:0] full_ofs;
    logic [dcff_pkg::AW-1:0] wptr;
    logic [dcff_pkg::AW-1:0] rptr;
    logic [dcff_pkg::LW-1:0] level;
    logic out_valid;
    logic [1:0] ft_cnt;
    logic rw_hold;
    logic load_sel;
    logic rd_sel;
    logic [dcff_pkg::WIDTH-1:0] out_word;
    logic oe;
    logic ev_flag;
    logic fs_flag;
    logic half;
    logic near_empty;
    logic near_full;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] hrdata;
    logic sw_clear;
    logic sw_rewind;
    logic rdy;
  } dcff_state_s;
  dcff_state_s s;
  dcff_state_s n;
  // Storage array
  logic [dcff_pkg::WIDTH-1:0] mem [dcff_pkg::DEPTH];
  logic [dcff_pkg::WIDTH-1:0] mem_word;
  logic wr_acc;
  logic rd_try;
  logic pop;
  logic rewind;
  logic quiet;
  // Asynchronous read of the head location
  assign mem_word = mem[s.rptr];
  assign quiet = full_init_n && data_only_init_n && !s.sw_clear;
  // ==========================================================
  // Next-state logic
  always_comb
  begin
    n = s;
    wr_acc = 1'b0;
    rd_try = 1'b0;
    pop = 1'b0;
    rewind = !rewind_request_n || s.sw_rewind;
    n.rw_hold = 1'b0;
    n.sw_clear = 1'b0;
    n.sw_rewind = 1'b0;
    n.rdy = 1'b1;
    // Bus write data phase: control pulses
    if (s.wr_pend && s.wr_addr == dcff_pkg::REG_CTRL)
    begin
      n.sw_clear = hwdata[dcff_pkg::CTRL_DATA_INIT];
      n.sw_rewind = hwdata[dcff_pkg::CTRL_REWIND];
    end
    // Bus address phase: capture write, prepare read data
    n.wr_pend = hsel && hready && htrans[dcff_pkg::HTRANS_ACT] && hwrite;
    n.wr_addr = haddr;
    n.hrdata = '0;
    if (hsel && hready && htrans[dcff_pkg::HTRANS_ACT] && !hwrite)
    begin
      case (haddr)
        dcff_pkg::REG_STATUS:
        begin
          n.hrdata[dcff_pkg::ST_EV] = s.ev_flag;
          n.hrdata[dcff_pkg::ST_FS] = s.fs_flag;
          n.hrdata[dcff_pkg::ST_HALF] = s.half;
          n.hrdata[dcff_pkg::ST_NE] = s.near_empty;
          n.hrdata[dcff_pkg::ST_NF] = s.near_full;
          n.hrdata[dcff_pkg::ST_MODE] = (s.mode == dcff_pkg::MODE_FT);
          n.hrdata[dcff_pkg::ST_PAR] = s.par_prog;
          n.hrdata[dcff_pkg::ST_LVL_LSB +: dcff_pkg::LW] = s.level;
        end
        dcff_pkg::REG_OFS:
        begin
          n.hrdata[dcff_pkg::OFS_EMPTY_LSB +: dcff_pkg::AW] = s.empty_ofs;
          n.hrdata[dcff_pkg::OFS_FULL_LSB +: dcff_pkg::AW] = s.full_ofs;
        end
        default:
          n.hrdata = '0;
      endcase
    end
    // Output drive follows enable
    n.oe = !output_enable_n;
    // Offset register access
    if (!offset_access_select_n)
    begin
      if (!s.par_prog && !serial_load_enable_n)
      begin
        // Shift chain: near-empty offset feeds near-full offset
        n.empty_ofs = {s.empty_ofs[dcff_pkg::AW-2:0], mode_select_serial_in};
        n.full_ofs = {s.full_ofs[dcff_pkg::AW-2:0], s.empty_ofs[dcff_pkg::AW-1]};
      end
      else if (s.par_prog && !write_n)
      begin
        // Alternate writes load near-empty then near-full
        if (!s.load_sel)
          n.empty_ofs = input_word[dcff_pkg::AW-1:0];
        else
          n.full_ofs = input_word[dcff_pkg::AW-1:0];
        n.load_sel = !s.load_sel;
      end
      if (!read_n)
      begin
        // Alternate reads return near-empty then near-full
        n.out_word = '0;
        n.out_word[dcff_pkg::AW-1:0] = s.rd_sel ? s.full_ofs : s.empty_ofs;
        n.rd_sel = !s.rd_sel;
      end
    end
    else
    begin
      wr_acc = !write_n && (s.level != dcff_pkg::DEPTH_L);
      rd_try = !read_n;
    end
    // Read side sequencing
    if (rewind)
    begin
      // Rewind: read pointer home, write side untouched
      n.rptr = '0;
      n.out_valid = 1'b0;
      n.ft_cnt = '0;
      n.rw_hold = 1'b1;
    end
    else if (s.mode == dcff_pkg::MODE_STD)
    begin
      // Word moves to outputs only on a read
      pop = rd_try && (s.level != '0);
    end
    else if (s.out_valid)
    begin
      if (rd_try)
      begin
        pop = (s.level != '0);
        n.out_valid = (s.level != '0);
      end
    end
    else if (s.level != '0)
    begin
      // First word falls through after fixed latency
      if (s.ft_cnt == dcff_pkg::FT_WAIT)
      begin
        pop = 1'b1;
        n.out_valid = 1'b1;
        n.ft_cnt = '0;
      end
      else
        n.ft_cnt = s.ft_cnt + 2'h1;
    end
    // Pointer and level update, both sides in one cycle
    if (pop)
    begin
      n.out_word = mem_word;
      n.rptr = s.rptr + 1'b1;
    end
    if (wr_acc)
      n.wptr = s.wptr + 1'b1;
    if (rewind)
      n.level = {1'b0, s.wptr} + dcff_pkg::LW'(wr_acc);
    else
      n.level = s.level + dcff_pkg::LW'(wr_acc) - dcff_pkg::LW'(pop);
    // Full init: strap mode, method and default offsets
    if (!full_init_n)
    begin
      n.mode = mode_select_serial_in ? dcff_pkg::MODE_FT : dcff_pkg::MODE_STD;
      n.par_prog = !offset_access_select_n;
      n.empty_ofs = n.par_prog ? dcff_pkg::OFS_PAR_DEF : dcff_pkg::OFS_SER_DEF;
      n.full_ofs = n.empty_ofs;
    end
    // Either init: clear data path, keep settings otherwise
    if (!quiet)
    begin
      n.wptr = '0;
      n.rptr = '0;
      n.level = '0;
      n.out_word = '0;
      n.out_valid = 1'b0;
      n.ft_cnt = '0;
      n.rw_hold = 1'b0;
      n.load_sel = 1'b0;
      n.rd_sel = 1'b0;
    end
    // Flags from the settled next state
    n.half = n.level > dcff_pkg::HALF_L;
    n.near_empty = n.level <= {1'b0, n.empty_ofs};
    n.near_full = n.level >= dcff_pkg::DEPTH_L - {1'b0, n.full_ofs};
    if (n.mode == dcff_pkg::MODE_FT)
    begin
      n.ev_flag = n.out_valid;
      n.fs_flag = n.level != dcff_pkg::DEPTH_L;
    end
    else
    begin
      n.ev_flag = (n.level == '0) || n.rw_hold;
      n.fs_flag = n.level == dcff_pkg::DEPTH_L;
    end
  end
  // ==========================================================
  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.ev_flag <= 1'b1;
      s.near_empty <= 1'b1;
      s.rdy <= 1'b1;
    end
    else
      s <= n;
  end

  // Storage write port
  always_ff @(posedge hclk)
  begin
    if (wr_acc)
      mem[s.wptr] <= input_word;
  end
  // ==========================================================
  // Outputs
  assign hreadyout = s.rdy;
  assign hresp = 1'b0 & s.rdy;
  assign hrdata = s.hrdata;
  assign output_word = s.out_word;
  assign output_word_oe = s.oe;
  assign empty_valid_flag = s.ev_flag;
  assign full_space_flag = s.fs_flag;
  assign half_level_flag = s.half;
  assign near_empty_flag = s.near_empty;
  assign near_full_flag = s.near_full;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Full buffer refuses writes
  property p_full_hold;
    s.level == dcff_pkg::DEPTH_L && !write_n && offset_access_select_n && quiet
      |=> s.wptr == $past(s.wptr);
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("write pointer moved while full");
  // Accepted write advances write pointer
  property p_write_adv;
    wr_acc && quiet |=> s.wptr == dcff_pkg::AW'($past(s.wptr) + 1'b1);
  endproperty
  a_write_adv: assert property (p_write_adv) else $error("write pointer did not advance");
  // Standard read of a non-empty buffer advances read pointer
  property p_std_read;
    s.mode == dcff_pkg::MODE_STD && rd_try && s.level != '0 && !rewind && quiet
      |=> s.rptr == dcff_pkg::AW'($past(s.rptr) + 1'b1) && s.out_word == $past(mem_word);
  endproperty
  a_std_read: assert property (p_std_read) else $error("standard read failed");
  // Full init clears pointers and output
  property p_full_init;
    !full_init_n |=> s.wptr == '0 && s.rptr == '0 && s.out_word == '0 && s.ev_flag == (s.mode == dcff_pkg::MODE_STD);
  endproperty
  a_full_init: assert property (p_full_init) else $error("full init incomplete");
  // Default offset chosen at full init
  property p_default_ofs;
    !full_init_n && !offset_access_select_n
      |=> s.empty_ofs == dcff_pkg::OFS_PAR_DEF && s.full_ofs == dcff_pkg::OFS_PAR_DEF && s.par_prog;
  endproperty
  a_default_ofs: assert property (p_default_ofs) else $error("default offset wrong");
  // Data-only init keeps offsets and mode
  property p_data_init;
    full_init_n && !data_only_init_n
      |=> $stable(s.empty_ofs) && $stable(s.full_ofs) && $stable(s.mode) && s.level == '0;
  endproperty
  a_data_init: assert property (p_data_init) else $error("data-only init lost settings");
  // Rewind returns read pointer home and holds write pointer
  property p_rewind;
    !rewind_request_n && quiet && !wr_acc |=> s.rptr == '0 && $stable(s.wptr);
  endproperty
  a_rewind: assert property (p_rewind) else $error("rewind failed");
  // Half flag tracks stored level
  property p_half;
    s.half == (s.level > dcff_pkg::HALF_L);
  endproperty
  a_half: assert property (p_half) else $error("half flag wrong");
  // First word falls through on the second edge after its write
  property p_fall_through;
    s.mode == dcff_pkg::MODE_FT && !s.out_valid && s.level == '0 && wr_acc && quiet && !rewind
      ##1 (quiet && !rewind)[*2] |=> s.out_valid;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("fall-through latency wrong");
  // Main scenarios
  c_full: cover property (s.fs_flag && s.mode == dcff_pkg::MODE_STD);
  c_ft_valid: cover property (s.mode == dcff_pkg::MODE_FT && $rose(s.out_valid));
  c_rewind: cover property (!rewind_request_n && s.level != '0);
  c_serial: cover property (!offset_access_select_n && !serial_load_enable_n && !s.par_prog);
endmodule : dcff_top

//--- common/dcff_pkg.sv
// Constants and types shared by the deep first-in-first-out buffer
package dcff_pkg;

  // ==========================================================
  // Storage geometry
  localparam int WIDTH = 18;
  localparam int DEPTH = 8192;
  localparam int AW = 13;
  localparam int LW = 14;
  localparam logic [LW-1:0] DEPTH_L = 14'h2000;
  localparam logic [LW-1:0] HALF_L = 14'h1000;

  // ==========================================================
  // Threshold defaults picked at full init
  localparam logic [AW-1:0] OFS_PAR_DEF = 13'h007f;
  localparam logic [AW-1:0] OFS_SER_DEF = 13'h03ff;

  // ==========================================================
  // Fall-through latency in edges, counting the write edge
  localparam logic [1:0] FT_LAT = 2'h3;
  localparam logic [1:0] FT_WAIT = FT_LAT - 2'h2;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [31:0] REG_STATUS = 32'h0000_0000;
  localparam logic [31:0] REG_OFS = 32'h0000_0004;
  localparam logic [31:0] REG_CTRL = 32'h0000_0008;

  // Status fields
  localparam int ST_EV = 0;
  localparam int ST_FS = 1;
  localparam int ST_HALF = 2;
  localparam int ST_NE = 3;
  localparam int ST_NF = 4;
  localparam int ST_MODE = 5;
  localparam int ST_PAR = 6;
  localparam int ST_LVL_LSB = 16;

  // Offset readback and control fields
  localparam int OFS_EMPTY_LSB = 0;
  localparam int OFS_FULL_LSB = 16;
  localparam int CTRL_DATA_INIT = 0;
  localparam int CTRL_REWIND = 1;
  localparam int HTRANS_ACT = 1;

  // ==========================================================
  // Timing modes
  typedef enum logic {
    MODE_STD,
    MODE_FT
  } dcff_mode_e;

endpackage : dcff_pkg

//--- sim/dcff_partner.sv
// Writer and reader logic facing the buffer's data ports
`timescale 1ns/10ps
module dcff_partner
(
  // Clock
  input wire logic hclk,
  // Bench requests and first word value
  input wire logic wr_on,
  input wire logic rd_on,
  input wire logic [17:0] base,
  // Buffer side
  output logic write_n = 1'b1,
  output logic [17:0] input_word = 18'h0,
  output logic read_n = 1'b1
);
  logic [17:0] seq = 18'h0;
  // Writer: numbered words on strobe, inverted bus while idle
  always @(posedge hclk)
  begin
    write_n <= !wr_on;
    seq <= wr_on ? seq + 18'h1 : seq;
    input_word <= wr_on ? base + seq : ~input_word;
  end
  // Reader: strobe while asked
  always @(posedge hclk)
  begin
    read_n <= !rd_on;
  end
endmodule : dcff_partner

//--- sim/dual_clock_fifo_with_flags_tb.sv
// Self-checking bench for the deep word buffer
`timescale 1ns/10ps
module dual_clock_fifo_with_flags_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, write_n, read_n, oe, ev, fs, hl, ne, nf;
  logic wr_on = 1'b0, rd_on = 1'b0, oen = 1'b1, fin = 1'b1, rwn = 1'b1, msi = 1'b0, osn = 1'b1;
  logic ser_n = 1'b1, clr_n = 1'b1;
  logic [17:0] input_word, output_word;
  logic [17:0] base = 18'h0;
  logic [25:0] bits;
  int err_total = 0, samples_checked = 0, nw = 0, first = 0;
  always #4 hclk = ~hclk;
  // Design and partner
  dcff_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .write_n(write_n), .input_word(input_word), .read_n(read_n),
    .output_enable_n(oen), .output_word(output_word), .output_word_oe(oe), .full_init_n(fin),
    .data_only_init_n(clr_n), .rewind_request_n(rwn), .mode_select_serial_in(msi),
    .offset_access_select_n(osn), .serial_load_enable_n(ser_n), .empty_valid_flag(ev),
    .full_space_flag(fs), .half_level_flag(hl), .near_empty_flag(ne), .near_full_flag(nf));
  dcff_partner i_far (.hclk(hclk), .wr_on(wr_on), .rd_on(rd_on), .base(base), .write_n(write_n),
    .input_word(input_word), .read_n(read_n));
  // ==========================================================
  // Bench tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Single word transfer, waits on hready in both phases
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do cyc(1); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do cyc(1); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic lvl(input logic [31:0] e);
    ahb(1'b0, dcff_pkg::REG_STATUS, 32'h0);
    chk("level", e, {18'h0, rd[29:16]});
  endtask : lvl
  task automatic push(input int k);
    wr_on <= 1'b1;
    cyc(k);
    wr_on <= 1'b0;
    nw += k;
    cyc(3);
  endtask : push
  task automatic pull(input int k);
    rd_on <= 1'b1;
    cyc(k);
    rd_on <= 1'b0;
    cyc(3);
  endtask : pull
  task automatic init(input logic m, input logic s);
    msi <= m;
    osn <= s;
    fin <= 1'b0;
    cyc(1);
    fin <= 1'b1;
    osn <= 1'b1;
    msi <= 1'b0;
    cyc(2);
    first = nw;
  endtask : init
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Watchdog
  initial
  begin
    cyc(40000);
    err_total++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'he4bf126c));
    base = 18'($urandom);
    cyc(16);
    hresetn <= 1'b1;
    cyc(1);
    init(1'b0, 1'b0);
    chk("empty", 32'h1, {31'h0, ev});
    ahb(1'b0, dcff_pkg::REG_OFS, 32'h0);
    chk("offsets", 32'h007f_007f, rd);
    ahb(1'b0, dcff_pkg::REG_STATUS, 32'h0);
    chk("mode", 32'h40, rd & 32'h60);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Parallel offset load and readback
    osn <= 1'b0;
    push(2);
    ahb(1'b0, dcff_pkg::REG_OFS, 32'h0);
    chk("par offsets", {3'h0, 13'(base + 18'(first + 1)), 3'h0, 13'(base + 18'(first))}, rd);
    pull(1);
    osn <= 1'b1;
    chk("readback", 32'(13'(base + 18'(first))), {19'h0, output_word[12:0]});
    // Level boundaries, standard mode
    init(1'b0, 1'b0);
    push(127);
    chk("near empty", 32'h1, {31'h0, ne});
    push(1);
    chk("near empty", 32'h0, {31'h0, ne});
    chk("no read", 32'h0, {14'h0, output_word});
    lvl(32'h80);
    push(3968);
    chk("half", 32'h0, {31'h0, hl});
    push(1);
    chk("half", 32'h1, {31'h0, hl});
    push(3967);
    chk("near full", 32'h0, {31'h0, nf});
    push(1);
    chk("near full", 32'h1, {31'h0, nf});
    push(130);
    chk("full", 32'h1, {31'h0, fs});
    lvl(32'h2000);
    pull(1);
    chk("word", 32'(base + 18'(first)), {14'h0, output_word});
    chk("full", 32'h0, {31'h0, fs});
    // Data-only init keeps offsets, clears data
    ahb(1'b1, dcff_pkg::REG_CTRL, 32'h1);
    cyc(3);
    chk("empty", 32'h1, {31'h0, ev});
    chk("cleared", 32'h0, {14'h0, output_word});
    ahb(1'b0, dcff_pkg::REG_OFS, 32'h0);
    chk("kept offsets", 32'h007f_007f, rd);
    // Data-only init pin empties the buffer
    push(2);
    clr_n <= 1'b0;
    cyc(1);
    clr_n <= 1'b1;
    cyc(2);
    lvl(32'h0);
    chk("pin empty", 32'h1, {31'h0, ev});
    // Rewind rereads from the first location
    first = nw;
    push(3);
    pull(2);
    rwn <= 1'b0;
    cyc(1);
    rwn <= 1'b1;
    cyc(2);
    pull(1);
    chk("reread", 32'(base + 18'(first)), {14'h0, output_word});
    lvl(32'h2);
    oen <= 1'b0;
    cyc(2);
    chk("drive", 32'h1, {31'h0, oe});
    oen <= 1'b1;
    cyc(2);
    chk("drive", 32'h0, {31'h0, oe});
    // Fall-through mode, serial defaults
    init(1'b1, 1'b1);
    chk("space", 32'h1, {31'h0, fs});
    ahb(1'b0, dcff_pkg::REG_OFS, 32'h0);
    chk("offsets", 32'h03ff_03ff, rd);
    wr_on <= 1'b1;
    cyc(1);
    wr_on <= 1'b0;
    nw += 1;
    cyc(3);
    chk("valid early", 32'h0, {31'h0, ev});
    cyc(1);
    chk("valid", 32'h1, {31'h0, ev});
    chk("fall word", 32'(base + 18'(first)), {14'h0, output_word});
    push(1);
    chk("held", 32'(base + 18'(first)), {14'h0, output_word});
    pull(1);
    chk("next", 32'(base + 18'(first + 1)), {14'h0, output_word});
    // Serial offset load
    bits = 26'($urandom);
    osn <= 1'b0;
    ser_n <= 1'b0;
    for (int i = 25; i >= 0; i--)
    begin
      msi <= bits[i];
      cyc(1);
    end
    ser_n <= 1'b1;
    osn <= 1'b1;
    cyc(2);
    ahb(1'b0, dcff_pkg::REG_OFS, 32'h0);
    chk("ser offsets", {3'h0, bits[25:13], 3'h0, bits[12:0]}, rd);
    wrap_up();
  end
endmodule : dual_clock_fifo_with_flags_tb
